// *** rtl/sld_defines.svh ***
// Timing constants and reset values for the serial LED segment driver.
// Assumes the includer runs on mclk at 25 MHz.
`ifndef SLD_DEFINES_SVH
`define SLD_DEFINES_SVH

`define SLD_MCLK_NS          40
`define SLD_DOUT_DELAY_NS    500
// Longest cascade output delay, rounded down to whole mclk cycles
`define SLD_DOUT_DELAY_CYC   (`SLD_DOUT_DELAY_NS / `SLD_MCLK_NS)
`define SLD_SEG_RESET        16'h0000
`define SLD_WIDE_OUTS        16
`define SLD_NARROW_CHAIN     12

`endif

// *** rtl/sld_pkg.sv ***
// Types shared by the serial LED segment driver modules.
// Assumes the defines header is compiled alongside.
package sld_pkg;
	// One sampled view of the three serial pins
	typedef struct packed {
		logic din;
		logic sclk;
		logic en;
	} sld_pins_s;

	// Link edge events found on the sampled clock
	typedef struct packed {
		logic rise;
		logic fall;
	} sld_edge_s;

	typedef enum logic [1:0] {
		SLD_IDLE  = 2'b01,
		SLD_SHIFT = 2'b10
	} sld_state_e;
endpackage : sld_pkg

// *** rtl/sld_pin_sync.sv ***
// Two-flop synchroniser for the serial pins plus edge finder.
// Assumes pins are asynchronous to mclk and slow against it.
`timescale 1ns/1ns
module sld_pin_sync (
	input  wire logic              mclk,   // System clock
	input  wire logic              arst_n, // Async reset, active low
	input  wire sld_pkg::sld_pins_s pins,  // Raw pin levels
	output sld_pkg::sld_pins_s     synced, // Pin levels after two flops
	output sld_pkg::sld_edge_s     edges   // One-cycle clock edge pulses
);
	sld_pkg::sld_pins_s meta;
	logic               sclk_prev;

	// First stage feeds only the second stage
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta   <= '0;
			synced <= '0;
		end else begin
			meta   <= pins;
			synced <= meta;
		end
	end

	// Edge detection looks only at the settled copy
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= synced.sclk;
		end
	end

	assign edges.rise = synced.sclk & ~sclk_prev;
	assign edges.fall = ~synced.sclk & sclk_prev;
endmodule : sld_pin_sync

// *** rtl/sld_skid.sv ***
// Two-entry buffer with valid/ready on both sides.
// Assumes source and sink share mclk.
`timescale 1ns/1ns
module sld_skid #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input  wire logic             mclk,    // System clock
	input  wire logic             arst_n,  // Async reset, active low
	input  wire logic             s_valid, // Word offered
	output logic                  s_ready, // Room for a word
	input  wire logic [WIDTH-1:0] s_data,  // Incoming word
	output logic                  m_valid, // Word available
	input  wire logic             m_ready, // Sink takes word
	output logic      [WIDTH-1:0] m_data   // Outgoing word
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign s_ready = (count != (AW+1)'(DEPTH));
	assign m_valid = (count != '0);
	assign m_data  = mem[rd_idx];
	assign push    = s_valid & s_ready;
	assign pop     = m_valid & m_ready;

	// Storage written by index, no reset needed on data
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_idx] <= s_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
			end
			if (pop) begin
				rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sld_skid

// *** rtl/sld_driver.sv ***
// Serial-input latched LED segment driver, sampled on mclk.
// Assumes the serial pins are asynchronous and far slower than mclk.
`timescale 1ns/1ns
`include "sld_defines.svh"

module sld_driver #(
	parameter int NUM_OUTS = `SLD_WIDE_OUTS
) (
	input  wire logic                mclk,      // System clock, 25 MHz
	input  wire logic                arst_n,    // Async reset, active low
	input  wire logic                ser_din,   // Serial data pin
	input  wire logic                ser_clk,   // Serial clock pin
	input  wire logic                ser_en,    // Load enable pin
	output logic                     ser_dout,  // Cascade data out
	output logic      [NUM_OUTS-1:0] seg_on,    // Segment drive, 1 = on
	input  wire logic                seg_ready, // Display side accepts update
	output logic                     load_busy  // Update waiting in buffer
);
	// Chain length.
	// The narrow build still carries a 12-bit chain; its spare stage is
	// the one nearest the data pin, so it holds the last, don't-care bit.
	// Any build narrower than that keeps the same 12 stages.
	localparam int CHAIN = (NUM_OUTS < `SLD_NARROW_CHAIN) ? `SLD_NARROW_CHAIN :
		NUM_OUTS;

	// Cascade delay limit in whole mclk cycles, at least one.
	// The cascade path below takes a fixed four cycles from the pin edge,
	// which stays inside this limit for the documented delay.
	localparam int DLY = (`SLD_DOUT_DELAY_CYC < 1) ? 1 : `SLD_DOUT_DELAY_CYC;

	// Pin views before and after the synchroniser
	sld_pkg::sld_pins_s  pins;
	sld_pkg::sld_pins_s  synced;
	sld_pkg::sld_edge_s  edges;

	// Frame tracking
	sld_pkg::sld_state_e state;
	sld_pkg::sld_state_e next_state;
	logic                frame_open;
	logic                shift_step;

	// Shift chain and its next value
	logic [CHAIN-1:0]    shift_chain;
	logic [CHAIN-1:0]    next_chain;

	// Latch transfer path through the buffer
	logic                load_req;
	logic [NUM_OUTS-1:0] load_word;
	logic                buf_ready;
	logic                buf_valid;
	logic [NUM_OUTS-1:0] buf_data;
	logic                take;
	wire  [NUM_OUTS-1:0] next_seg;

	// Status and cascade
	logic                next_busy;
	logic                dout_pend;
	logic                next_dout;

	// Picks the segment field out of the chain.
	// Outputs sit at the far end of the chain, so the first bit shifted
	// drives the highest output whatever the chain length is.
	function automatic logic [NUM_OUTS-1:0] seg_field(input logic [CHAIN-1:0] chain);
		seg_field = chain[CHAIN-1 -: NUM_OUTS];
	endfunction : seg_field

	// Bit that leaves the far end of the chain, shown on the cascade pin
	function automatic logic chain_end(input logic [CHAIN-1:0] chain);
		chain_end = chain[CHAIN-1];
	endfunction : chain_end

	// Three pins only; no extra load strobe exists
	assign pins.din  = ser_din;
	assign pins.sclk = ser_clk;
	assign pins.en   = ser_en;

	// All three pins share one synchroniser so their relative timing,
	// which the host sets up with wide margins, is kept after sampling.
	sld_pin_sync u_sync (
		.mclk   (mclk),
		.arst_n (arst_n),
		.pins   (pins),
		.synced (synced),
		.edges  (edges)
	);

	// Frame state, next value.
	// A frame opens when the synchronised enable is seen high and closes
	// the first cycle it is seen low again.
	always_comb begin
		next_state = state;
		case (state)
			sld_pkg::SLD_IDLE: begin
				if (synced.en) begin
					next_state = sld_pkg::SLD_SHIFT;
				end
			end
			sld_pkg::SLD_SHIFT: begin
				if (!synced.en) begin
					next_state = sld_pkg::SLD_IDLE;
				end
			end
			default: begin
				next_state = sld_pkg::SLD_IDLE;
			end
		endcase
	end

	// Frame state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= sld_pkg::SLD_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Frame decodes: frame_open for the latch request, shift_step for the chain
	assign frame_open = (state == sld_pkg::SLD_SHIFT);
	assign shift_step = synced.en & edges.rise;

	// Chain next value.
	// Link clock edges outside a frame are dropped here, so stray clocks
	// on a shared clock line cannot disturb a pattern being built.
	always_comb begin
		next_chain = shift_chain;
		if (shift_step) begin
			next_chain = {shift_chain[CHAIN-2:0], synced.din};
		end
	end

	// Chain register, cleared only by reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			shift_chain <= '0;
		end else begin
			shift_chain <= next_chain;
		end
	end

	// Enable falling asks for a latch transfer.
	// The frame state still shows the frame open in that first cycle,
	// so the request is exactly one cycle long.
	assign load_req  = frame_open & ~synced.en;
	assign load_word = seg_field(shift_chain);

	// Buffer the new pattern so a stalled display loses no update.
	// If it is full, the load is dropped; that needs two stalled frames.
	sld_skid #(
		.WIDTH (NUM_OUTS),
		.DEPTH (2)
	) u_buf (
		.mclk    (mclk),
		.arst_n  (arst_n),
		.s_valid (load_req),
		.s_ready (buf_ready),
		.s_data  (load_word),
		.m_valid (buf_valid),
		.m_ready (seg_ready),
		.m_data  (buf_data)
	);

	// A buffered pattern moves to the latches when the display takes it
	assign take = buf_valid & seg_ready;

	// Per-segment next value.
	// Each latch keeps its bit unless a transfer happens; shifting never
	// reaches the latches, so the old pattern stays lit meanwhile.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUTS; gi++) begin : g_seg
			assign next_seg[gi] = take ? buf_data[gi] : seg_on[gi];
		end
	endgenerate

	// Output latches; a one lights its segment
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			seg_on <= NUM_OUTS'(`SLD_SEG_RESET);
		end else begin
			seg_on <= next_seg;
		end
	end

	// Busy shows a pattern that waits for the display or a full buffer.
	// A full buffer means the next finished frame would be lost.
	always_comb begin
		next_busy = (buf_valid & ~seg_ready) | ~buf_ready;
	end

	// Busy register, so the output comes straight from a flip-flop
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			load_busy <= 1'b0;
		end else begin
			load_busy <= next_busy;
		end
	end

	// Falling link edge inside a frame arms the cascade update.
	// Edges after the frame has closed leave the cascade pin alone.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dout_pend <= 1'b0;
		end else begin
			dout_pend <= synced.en & edges.fall;
		end
	end

	// Cascade next value.
	// The chain end only moves on a rising edge, so presenting it after
	// the falling edge gives the next driver a half period of setup, less the four-cycle cascade path.
	always_comb begin
		next_dout = ser_dout;
		if (dout_pend) begin
			next_dout = chain_end(shift_chain);
		end
	end

	// Cascade pin register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ser_dout <= 1'b0;
		end else begin
			ser_dout <= next_dout;
		end
	end

	// The delay limit is a design check only; nothing in the logic
	// depends on it, so it is kept visible as a constant flag.
	logic unused_dly;
	assign unused_dly = (DLY == 0);
endmodule : sld_driver

// *** verification/sld_driver_properties.sv ***
// Checker for the segment driver ports.
// Assumes seg_ready is driven in the mclk domain.
`timescale 1ns/1ns
module sld_driver_chk #(
	parameter int NUM_OUTS = 16
) (
	input wire logic                mclk,      // System clock
	input wire logic                arst_n,    // Async reset
	input wire logic                ser_clk,   // Link clock pin
	input wire logic                ser_en,    // Enable pin
	input wire logic                ser_dout,  // Cascade out
	input wire logic [NUM_OUTS-1:0] seg_on,    // Segment drive
	input wire logic                seg_ready, // Display accepts
	input wire logic                load_busy  // Update waiting
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Eight cycles outlast the pin sync lag of a finished load
	AST_SEG_HOLD: assert property ((ser_en && seg_ready)[*8] |-> $stable(seg_on))
		else $error("segments moved in frame");
	AST_IDLE_SEG: assert property ((!ser_en && seg_ready)[*8] |-> $stable(seg_on))
		else $error("segments moved while idle");
	AST_IDLE_DOUT: assert property (!ser_en[*6] |-> $stable(ser_dout))
		else $error("cascade moved while idle");
	AST_DOUT_EDGE: assert property ($changed(ser_dout) |-> !$past(ser_clk, 2))
		else $error("cascade moved off a falling edge");
	AST_SEG_READY: assert property ($changed(seg_on) |-> $past(seg_ready))
		else $error("segments moved without ready");
	AST_RESET_OFF: assert property (disable iff (1'b0)
		!arst_n |-> seg_on == '0 && !ser_dout && !load_busy)
		else $error("outputs not clear in reset");
	AST_BUSY_DRAIN: assert property (seg_ready[*5] |-> !load_busy)
		else $error("buffer not drained");
	AST_BUSY_STALL: assert property (seg_ready[*3] |=> !$rose(load_busy))
		else $error("busy without a stall");
	cover property ($fell(ser_en));
	cover property ($rose(load_busy));
	cover property ($changed(seg_on));
endmodule : sld_driver_chk

bind sld_driver sld_driver_chk #(.NUM_OUTS(NUM_OUTS)) chk (.mclk(mclk), .arst_n(arst_n),
	.ser_clk(ser_clk), .ser_en(ser_en), .ser_dout(ser_dout), .seg_on(seg_on),
	.seg_ready(seg_ready), .load_busy(load_busy));

// *** verification/sld_host.sv ***
// Host model that shifts frames into the driver.
// Assumes mclk at 40 ns; link clock is 8 mclk a period.
`timescale 1ns/1ns
module sld_host (
	input  wire logic mclk,    // Bench clock
	output logic      ser_din, // Serial data
	output logic      ser_clk, // Link clock
	output logic      ser_en   // Load enable
);
	initial begin
		ser_din = 1'b0;
		ser_clk = 1'b0;
		ser_en  = 1'b0;
	end
	// Data moves with the falling edge, half a period clear of rising edges
	task automatic send(input logic [15:0] w, input int n);
		ser_en <= 1'b1;
		repeat (4) @(posedge mclk);
		for (int i = n - 1; i >= 0; i--) begin
			ser_din <= w[i];
			repeat (4) @(posedge mclk);
			ser_clk <= 1'b1;
			repeat (4) @(posedge mclk);
			ser_clk <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		ser_en  <= 1'b0;
		ser_din <= ~ser_din; // Released line shows no stale bit
		repeat (8) @(posedge mclk);
	endtask : send
	// Clock pulses with enable low, which must be ignored
	task automatic stray(input int n);
		ser_din <= 1'b1;
		repeat (n) begin
			ser_clk <= 1'b1;
			repeat (4) @(posedge mclk);
			ser_clk <= 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask : stray
endmodule : sld_host

// *** verification/serial_led_segment_driver_tb_top.sv ***
// Bench for the wide and narrow driver builds.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ns
module serial_led_segment_driver_tb_top;
	logic        mclk, arst_n, seg_ready, ser_din, ser_clk, ser_en;
	logic        dout_w, dout_n, busy_w, busy_n;
	logic [15:0] seg_w;
	logic [10:0] seg_n;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	sld_host host (.mclk(mclk), .ser_din(ser_din), .ser_clk(ser_clk), .ser_en(ser_en));
	sld_driver #(.NUM_OUTS(16)) uut (.mclk(mclk), .arst_n(arst_n), .ser_din(ser_din),
		.ser_clk(ser_clk), .ser_en(ser_en), .ser_dout(dout_w), .seg_on(seg_w),
		.seg_ready(seg_ready), .load_busy(busy_w));
	sld_driver #(.NUM_OUTS(11)) uut_n (.mclk(mclk), .arst_n(arst_n), .ser_din(ser_din),
		.ser_clk(ser_clk), .ser_en(ser_en), .ser_dout(dout_n), .seg_on(seg_n),
		.seg_ready(1'b1), .load_busy(busy_n));
	task check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task summarize;
		if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	// Hang guard, well above the few frames sent
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			summarize();
		end
	end
	task t_reset;
		check(seg_w, 16'h0000);
		check({3'h0, dout_w, dout_n, busy_w, busy_n, seg_n}, 16'h0000);
	endtask : t_reset
	task t_load;
		host.send(16'ha5c3, 16);
		check(seg_w, 16'ha5c3);
		check({5'h00, seg_n}, 16'h02e1);
		check({15'h0000, dout_w}, 16'h0001);
	endtask : t_load
	task t_stray;
		host.stray(4);
		host.send(16'h00f0, 12);
		check(seg_w, 16'h30f0);
		check({5'h00, seg_n}, 16'h0078);
	endtask : t_stray
	task t_stall;
		seg_ready <= 1'b0;
		host.send(16'h1234, 16);
		host.send(16'hbeef, 16);
		check({15'h0000, busy_w}, 16'h0001);
		check(seg_w, 16'h30f0);
		seg_ready <= 1'b1;
		repeat (8) @(posedge mclk);
		check(seg_w, 16'hbeef);
		check({15'h0000, busy_w}, 16'h0000);
	endtask : t_stall
	initial begin
		arst_n    = 1'b0;
		seg_ready = 1'b1;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_load();
		t_stray();
		t_stall();
		summarize();
	end
endmodule : serial_led_segment_driver_tb_top
